/* hw/dmlc_pkg.sv */
// dmlc_pkg: register offsets, field positions and reset values of the
// dither, sample marker and serial link configuration bank.
// assumes a 32-bit apb with one register per aligned word.
package dmlc_pkg;

    // ------------------------------------------------------------------
    // register indices (printed offsets) and byte address width
    // ------------------------------------------------------------------
    localparam logic [11:0] IDX_DITHER_CONTROL  = 12'h09d;
    localparam logic [11:0] IDX_OUTPUT_MARKER   = 12'h160;
    localparam logic [11:0] IDX_LINK_ENABLE     = 12'h200;
    localparam logic [11:0] IDX_LINK_MODE       = 12'h201;
    // own registers for loose bits that the bank refers to
    localparam logic [11:0] IDX_SYSTEM_CONTROL  = 12'h300;
    localparam logic [11:0] IDX_MODE_LOCK       = 12'h301;
    localparam logic [11:0] IDX_LINK_STATUS     = 12'h302;

    localparam int          ADDR_W              = 14;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_DITHER_CONTROL  = 8'h01;
    localparam logic [7:0]  RST_OUTPUT_MARKER   = 8'h00;
    localparam logic [7:0]  RST_LINK_ENABLE     = 8'h01;
    localparam logic [7:0]  RST_LINK_MODE       = 8'h02;
    localparam logic [7:0]  RST_SYSTEM_CONTROL  = 8'h01;
    localparam logic [7:0]  RST_MODE_LOCK       = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          BIT_DITHER_ENABLE   = 0;
    localparam int          BIT_DITHER_AMP      = 1;
    localparam int          BIT_DITHER_ROUND    = 2;
    localparam int          BIT_MARKER_ENABLE   = 0;
    localparam int          BIT_LINK_ENABLE     = 0;
    localparam int          BIT_CAL_ENABLE      = 0;
    localparam int          BIT_SYNC_RECV       = 1;
    localparam int          BIT_LOCK_ON         = 0;

    // highest mode code accepted while the mode lock is on
    localparam logic [7:0]  LOCKED_MODE_MAX     = 8'h03;
    localparam logic [7:0]  CS_COUNT            = 8'h00;
    localparam int          SAMPLE_W            = 8;
    localparam int          PIPE_DEPTH          = 4;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic dither_enable;
        logic dither_amplitude_select;
        logic dither_rounding_select;
    } dmlc_dither_t;

    typedef struct packed {
        logic       link_subsystem_enable;
        logic       link_reset;
        logic       serializer_power_down;
        logic       link_clock_gate;
        logic       multiframe_counter_reset;
        logic [7:0] link_mode_select;
    } dmlc_link_t;

endpackage : dmlc_pkg

/* hw/dmlc_marker_pipe.sv */
// dmlc_marker_pipe: carries samples and the timestamp through the same
// pipeline and puts the timestamp on the sample lsb when enabled.
// assumes the timestamp input is already synchronised to CLK.
`timescale 1ns/1ns
module dmlc_marker_pipe #(
    parameter int W     = dmlc_pkg::SAMPLE_W,   // sample width
    parameter int DEPTH = dmlc_pkg::PIPE_DEPTH  // pipeline stages
) (
    input  wire logic         clk,        // core clock
    input  wire logic         reset,      // synchronous, active high
    input  wire logic         marker_en,  // put marker on lsb
    input  wire logic [W-1:0] sample_raw,  // converted sample
    input  wire logic         stamp_bit,   // timestamp bit, synchronised
    output logic      [W-1:0] sample_mark  // sample with optional marker
);

    // ------------------------------------------------------------------
    // shared delay line
    // ------------------------------------------------------------------
    logic [W-1:0] data_reg  [DEPTH];
    logic         stamp_reg [DEPTH];

    // equal latency stages
    // sample and stamp move in lockstep, so the marker never slips
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_stage
            logic [W-1:0] data_feed;
            logic         stamp_feed;
            // stage 0 takes the inputs, later stages their neighbour
            if (i == 0) begin : g_head
                assign data_feed  = sample_raw;
                assign stamp_feed = stamp_bit;
            end else begin : g_tail
                assign data_feed  = data_reg[i-1];
                assign stamp_feed = stamp_reg[i-1];
            end
            always_ff @(posedge clk) begin
                if (reset) begin
                    data_reg[i]  <= '0;
                    stamp_reg[i] <= 1'b0;
                end else begin
                    data_reg[i]  <= data_feed;
                    stamp_reg[i] <= stamp_feed;
                end
            end
        end
    endgenerate

    // marker replaces lsb
    // upper bits keep conversion data, lsb carries the stamp
    logic [W-1:0] sample_next;
    assign sample_next = marker_en ?
        {data_reg[DEPTH-1][W-1:1], stamp_reg[DEPTH-1]} : data_reg[DEPTH-1];

    always_ff @(posedge clk) begin
        if (reset) sample_mark <= '0;
        else       sample_mark <= sample_next;
    end

endmodule : dmlc_marker_pipe

/* hw/dmlc_regs.sv */
// dmlc_regs: apb register bank for dither, sample marker and serial link
// enable and mode selection.
// assumes apb master on CLK; sample and timestamp pins arrive async.
//
// Contract
// - dither enable bit applies dither to the cores
// - amplitude bit: 0 small dither, 1 large dither
// - rounding bit: 0 costs snr, 1 costs dc offset and spurs
// - marker enable puts timestamp on every sample lsb
// - timestamp latency equals sample latency
// - marker in lsb of 8-bit sample, upper 7 bits data
// - ila control-bit count always reports zero
// - link enable bit 0 disables, 1 enables; resets to one
// - link disabled: held in reset, serializers off, clocks gated
// - link disabled: multiframe counter held, sysref ignored
// - 8-bit link mode register, reset 0x02
// - only mode codes permitted by the mode lock accepted
`timescale 1ns/1ns
module dmlc_regs #(
    parameter int SW = dmlc_pkg::SAMPLE_W  // sample width
) (
    input  wire logic          CLK,             // 125 mhz core clock
    input  wire logic          RESET,           // sync reset, high
    input  wire logic          PSEL,            // apb select
    input  wire logic          PENABLE,         // apb access phase
    input  wire logic          PWRITE,          // apb direction
    input  wire logic [31:0]   PADDR,           // apb byte address
    input  wire logic [31:0]   PWDATA,          // apb write data
    output logic      [31:0]   PRDATA,          // apb read data
    output logic               PREADY,          // apb ready
    output logic               PSLVERR,         // apb error
    input  wire logic [SW-1:0] SAMPLE_RAW,      // converter sample pins
    input  wire logic          STAMP,           // timestamp pin
    input  wire logic          SYSREF,          // system reference pin
    output logic [SW-1:0]      SAMPLE_LINK,     // sample to link
    output dmlc_pkg::dmlc_dither_t DITHER,      // dither controls
    output dmlc_pkg::dmlc_link_t   LINK,        // link controls
    output logic               SYNC_RECEIVER_ENABLE,    // sync receiver enable
    output logic               CAL_EN,          // calibration enable
    output logic [7:0]         ILA_CS,          // ila control-bit count
    output logic               MF_ALIGN         // multiframe align pulse
);
    default clocking @(posedge CLK); endclocking  // checks on core clock
    default disable iff (RESET);                  // checks idle in reset

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [7:0] dither_control_reg;
    logic [7:0] output_marker_control_reg;
    logic [7:0] serial_link_enable_reg;
    logic [7:0] serial_link_mode_reg;
    logic [7:0] system_control_reg;
    logic [7:0] mode_lock_reg;
    logic       mode_reject_reg;    // sticky: a mode write was refused since the last status read

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    // one-wait-state slave: access phase ends with pready next cycle
    logic        access;
    logic        wr_strobe;
    logic        rd_strobe;
    logic [11:0] index;
    logic        addr_ok;
    logic        sel_dith;
    logic        sel_mark;
    logic        sel_len;
    logic        sel_mode;
    logic        sel_sys;
    logic        sel_lock;
    logic        sel_stat;

    assign access    = PSEL && PENABLE && !PREADY;
    assign index     = PADDR[dmlc_pkg::ADDR_W-1:2];
    assign addr_ok   = (PADDR[1:0] == 2'h0) &&
                       (PADDR[31:dmlc_pkg::ADDR_W] == '0);
    assign sel_dith  = addr_ok && index == dmlc_pkg::IDX_DITHER_CONTROL;
    assign sel_mark  = addr_ok && index == dmlc_pkg::IDX_OUTPUT_MARKER;
    assign sel_len   = addr_ok && index == dmlc_pkg::IDX_LINK_ENABLE;
    assign sel_mode  = addr_ok && index == dmlc_pkg::IDX_LINK_MODE;
    assign sel_sys   = addr_ok && index == dmlc_pkg::IDX_SYSTEM_CONTROL;
    assign sel_lock  = addr_ok && index == dmlc_pkg::IDX_MODE_LOCK;
    assign sel_stat  = addr_ok && index == dmlc_pkg::IDX_LINK_STATUS;

    logic mapped;
    assign mapped    = sel_dith | sel_mark | sel_len | sel_mode |
                       sel_sys | sel_lock | sel_stat;
    assign wr_strobe = access && PWRITE && mapped && !sel_stat;
    assign rd_strobe = access && !PWRITE;

    // mode lock filter
    // lock on: codes above the locked ceiling are refused
    logic mode_allowed;
    assign mode_allowed = !mode_lock_reg[dmlc_pkg::BIT_LOCK_ON] ||
                          PWDATA[7:0] <= dmlc_pkg::LOCKED_MODE_MAX;

    // mode write window
    // hardware guards the mode too: a live link must not see it change
    logic mode_window;
    assign mode_window =
        !serial_link_enable_reg[dmlc_pkg::BIT_LINK_ENABLE] &&
        !system_control_reg[dmlc_pkg::BIT_CAL_ENABLE];

    logic mode_take;
    logic mode_refuse;
    assign mode_take   = wr_strobe && sel_mode && mode_allowed && mode_window;
    assign mode_refuse = wr_strobe && sel_mode && !mode_take;

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // reserved bits kept
    // whole byte stored; only defined bits drive logic
    always_ff @(posedge CLK) begin
        if (RESET) begin
            dither_control_reg        <= dmlc_pkg::RST_DITHER_CONTROL;
            output_marker_control_reg <= dmlc_pkg::RST_OUTPUT_MARKER;
            system_control_reg        <= dmlc_pkg::RST_SYSTEM_CONTROL;
            mode_lock_reg             <= dmlc_pkg::RST_MODE_LOCK;
        end else if (wr_strobe) begin
            if (sel_dith) dither_control_reg        <= PWDATA[7:0];
            if (sel_mark) output_marker_control_reg <= PWDATA[7:0];
            if (sel_sys)  system_control_reg        <= PWDATA[7:0];
            if (sel_lock) mode_lock_reg             <= PWDATA[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET)
            serial_link_enable_reg <= dmlc_pkg::RST_LINK_ENABLE;
        else if (wr_strobe && sel_len)
            serial_link_enable_reg <= PWDATA[7:0];
    end

    always_ff @(posedge CLK) begin
        if (RESET)          serial_link_mode_reg <= dmlc_pkg::RST_LINK_MODE;
        else if (mode_take) serial_link_mode_reg <= PWDATA[7:0];
    end

    // refused mode writes leave a flag; a read of status clears it,
    // but a refusal in the same cycle wins over that clear
    always_ff @(posedge CLK) begin
        if (RESET)            mode_reject_reg <= 1'b0;
        else if (mode_refuse) mode_reject_reg <= 1'b1;
        else if (rd_strobe && sel_stat) mode_reject_reg <= 1'b0;
    end

    // ------------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------------
    logic [7:0] rd_byte;
    assign rd_byte =
        sel_dith ? dither_control_reg :
        sel_mark ? output_marker_control_reg :
        sel_len  ? serial_link_enable_reg :
        sel_mode ? serial_link_mode_reg :
        sel_sys  ? system_control_reg :
        sel_lock ? mode_lock_reg :
        sel_stat ? {6'h00, mode_reject_reg, LINK.link_reset} : 8'h00;

    logic err_next;
    assign err_next = access && (!mapped || (PWRITE && sel_stat) ||
                                 mode_refuse);

    always_ff @(posedge CLK) begin
        if (RESET) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= access;
            PSLVERR <= err_next;
            PRDATA  <= rd_strobe ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // control outputs
    // ------------------------------------------------------------------
    logic link_on;
    assign link_on = serial_link_enable_reg[dmlc_pkg::BIT_LINK_ENABLE];

    always_ff @(posedge CLK) begin
        if (RESET) begin
            DITHER <= '0;
        end else begin
            DITHER.dither_enable <=
                dither_control_reg[dmlc_pkg::BIT_DITHER_ENABLE];
            DITHER.dither_amplitude_select <=
                dither_control_reg[dmlc_pkg::BIT_DITHER_AMP];
            DITHER.dither_rounding_select <=
                dither_control_reg[dmlc_pkg::BIT_DITHER_ROUND];
        end
    end

    // link held off
    // reset, power down, gate and counter hold all follow enable low
    always_ff @(posedge CLK) begin
        if (RESET) begin
            LINK <= '0;
        end else begin
            LINK.link_subsystem_enable    <= link_on;
            LINK.link_reset               <= !link_on;
            LINK.serializer_power_down    <= !link_on;
            LINK.link_clock_gate          <= !link_on;
            LINK.multiframe_counter_reset <= !link_on;
            LINK.link_mode_select         <= serial_link_mode_reg;
        end
    end

    // ila count zero
    // marker is never advertised, whatever the lsb carries
    always_ff @(posedge CLK) ILA_CS <= dmlc_pkg::CS_COUNT;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            SYNC_RECEIVER_ENABLE <= 1'b0;
            CAL_EN       <= 1'b0;
        end else begin
            SYNC_RECEIVER_ENABLE <= system_control_reg[dmlc_pkg::BIT_SYNC_RECV];
            CAL_EN       <= system_control_reg[dmlc_pkg::BIT_CAL_ENABLE];
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // second stage only is read; sample bits are assumed quasi-static
    // relative to CLK in this model of the output path
    logic [SW-1:0] samp_s1_reg;
    logic [SW-1:0] samp_s2_reg;
    logic          stamp_s1_reg;
    logic          stamp_s2_reg;
    logic          sysref_s1_reg;
    logic          sysref_s2_reg;
    logic          sysref_d_reg;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            samp_s1_reg   <= '0;
            samp_s2_reg   <= '0;
            stamp_s1_reg  <= 1'b0;
            stamp_s2_reg  <= 1'b0;
            sysref_s1_reg <= 1'b0;
            sysref_s2_reg <= 1'b0;
            sysref_d_reg  <= 1'b0;
        end else begin
            samp_s1_reg   <= SAMPLE_RAW;
            samp_s2_reg   <= samp_s1_reg;
            stamp_s1_reg  <= STAMP;
            stamp_s2_reg  <= stamp_s1_reg;
            sysref_s1_reg <= SYSREF;
            sysref_s2_reg <= sysref_s1_reg;
            sysref_d_reg  <= sysref_s2_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) MF_ALIGN <= 1'b0;
        else       MF_ALIGN <= link_on && sysref_s2_reg && !sysref_d_reg;
    end

    // ------------------------------------------------------------------
    // sample marker path
    // ------------------------------------------------------------------
    // marker enable to pipe
    dmlc_marker_pipe #(
        .W     (SW),
        .DEPTH (dmlc_pkg::PIPE_DEPTH)
    ) u_pipe (
        .clk         (CLK),
        .reset       (RESET),
        .marker_en   (output_marker_control_reg[dmlc_pkg::BIT_MARKER_ENABLE]),
        .sample_raw  (samp_s2_reg),
        .stamp_bit   (stamp_s2_reg),
        .sample_mark (SAMPLE_LINK)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    link_reset_off_a: assert property (
        !link_on |=> LINK.link_reset && LINK.serializer_power_down &&
                     LINK.link_clock_gate)
        else $error("link not held off while disabled");
    mf_hold_a: assert property (
        !link_on |=> !MF_ALIGN && LINK.multiframe_counter_reset)
        else $error("multiframe counter not held");
    mode_guard_a: assert property (
        (wr_strobe && sel_mode && !mode_window) |=>
            $stable(serial_link_mode_reg))
        else $error("mode changed while link or cal on");
    mode_lock_a: assert property (
        (wr_strobe && sel_mode && !mode_allowed) |=>
            $stable(serial_link_mode_reg) && mode_reject_reg)
        else $error("locked mode code accepted");
    ila_zero_a: assert property (
        ILA_CS == dmlc_pkg::CS_COUNT)
        else $error("ila control-bit count not zero");
    dither_follow_a: assert property (
        (wr_strobe && sel_dith) |=> ##1
            DITHER.dither_enable == $past(PWDATA[0], 2))
        else $error("dither enable not applied");
    dither_amp_a: assert property (
        (wr_strobe && sel_dith) |=> ##1
            DITHER.dither_amplitude_select == $past(PWDATA[1], 2))
        else $error("dither amplitude not applied");
    dither_round_a: assert property (
        (wr_strobe && sel_dith) |=> ##1
            DITHER.dither_rounding_select == $past(PWDATA[2], 2))
        else $error("rounding select not applied");
    marker_lsb_a: assert property (
        $stable(output_marker_control_reg) [*6] ##0
        output_marker_control_reg[0] |->
            SAMPLE_LINK[0] == $past(stamp_s2_reg, 5))
        else $error("marker lsb misaligned");
    link_rst_val_a: assert property (
        $fell(RESET) |->
            serial_link_enable_reg == dmlc_pkg::RST_LINK_ENABLE &&
            serial_link_mode_reg == dmlc_pkg::RST_LINK_MODE)
        else $error("link reset values wrong");
    apb_ready_a: assert property (
        (access && !PWRITE && sel_dith) |=>
            PREADY && PRDATA[7:0] == $past(dither_control_reg))
        else $error("stored byte not read back");

endmodule : dmlc_regs

/* verif/tb_dmlc_regs.sv */
// tb_dmlc_regs: self-checking bench for the dither, marker and link bank.
// assumes a one-wait-state apb slave and pins synchronised inside the block.
`timescale 1ns/1ns
module tb_dmlc_regs;
    logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    logic        pready, pslverr, err, stamp = 0, sysref = 0;
    logic [7:0]  smp = 8'h00, smp_out, ila_cs;
    logic        sync_en, cal_en, mf_align;
    dmlc_pkg::dmlc_dither_t dith;
    dmlc_pkg::dmlc_link_t   link;
    int          fail_count = 0, compares = 0, hits;

    dmlc_regs DUT (.CLK(clk), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SAMPLE_RAW(smp), .STAMP(stamp),
        .SYSREF(sysref), .SAMPLE_LINK(smp_out), .DITHER(dith),
        .LINK(link), .SYNC_RECEIVER_ENABLE(sync_en), .CAL_EN(cal_en),
        .ILA_CS(ila_cs), .MF_ALIGN(mf_align));

    // 8 ns period
    always #4 clk = ~clk;

    task automatic print_verdict();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] idx,
                       input logic [7:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {18'h0, idx, 2'b00};
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            $display("FAIL pready expected 1 seen timeout");
            print_verdict();
        end
    endtask : apb

    task automatic wr(input logic [11:0] i, input logic [7:0] d,
                      input logic e);
        apb(1'b1, i, d);
        chk("pslverr", {31'h0, e}, {31'h0, err});
    endtask : wr

    task automatic rdc(input logic [11:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk("prdata", {24'h0, e}, rd);
    endtask : rdc

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // sysref edge, count align pulses over a bounded window
    task automatic ref_pulse();
        hits = 0;
        sysref <= 1'b1;
        repeat (10) begin
            @(posedge clk);
            if (mf_align === 1'b1) hits++;
        end
        sysref <= 1'b0;
        tick(5);
    endtask : ref_pulse

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        tick(2);
        rdc(12'h09d, 8'h01);
        rdc(12'h160, 8'h00);
        rdc(12'h200, 8'h01);
        rdc(12'h201, 8'h02);
        rdc(12'h300, 8'h01);
        rdc(12'h301, 8'h00);
        chk("dither", 32'h4, {29'h0, dith});
        chk("link", 32'h1002, {19'h0, link});
        chk("ila_cs", 32'h0, {24'h0, ila_cs});
        chk("cal_en", 32'h1, {31'h0, cal_en});
        chk("sync_en", 32'h0, {31'h0, sync_en});
        $display("test reset done");
        // each dither field alone, then reserved bits only
        for (int k = 0; k < 4; k++) begin
            logic [7:0] v;
            v = (k == 3) ? 8'hf8 : 8'h01 << k;
            wr(12'h09d, v, 1'b0);
            tick(2);
            chk("dither", {29'h0, v[0], v[1], v[2]}, {29'h0, dith});
            rdc(12'h09d, v);
        end
        $display("test dither done");
        wr(12'h200, 8'h00, 1'b0);
        tick(2);
        chk("link ctl", 32'h0f, {27'h0, link[12:8]});
        rdc(12'h302, 8'h01);
        ref_pulse();
        chk("mf_align", 32'h0, hits);
        wr(12'h201, 8'h05, 1'b1);
        wr(12'h300, 8'h00, 1'b0);
        wr(12'h201, 8'h05, 1'b0);
        tick(2);
        chk("mode", 32'h05, {24'h0, link[7:0]});
        chk("cal_en", 32'h0, {31'h0, cal_en});
        wr(12'h301, 8'h01, 1'b0);
        wr(12'h201, 8'h04, 1'b1);
        rdc(12'h302, 8'h03);
        rdc(12'h302, 8'h01);
        wr(12'h201, 8'h03, 1'b0);
        wr(12'h301, 8'h00, 1'b0);
        wr(12'h300, 8'h03, 1'b0);
        wr(12'h200, 8'h01, 1'b0);
        tick(2);
        chk("link ctl", 32'h10, {27'h0, link[12:8]});
        chk("mode", 32'h03, {24'h0, link[7:0]});
        chk("cal_en", 32'h1, {31'h0, cal_en});
        chk("sync_en", 32'h1, {31'h0, sync_en});
        ref_pulse();
        chk("mf_align", 32'h1, hits);
        wr(12'h201, 8'h02, 1'b1);
        rdc(12'h201, 8'h03);
        $display("test link done");
        wr(12'h160, 8'h01, 1'b0);
        smp   <= 8'ha4;
        stamp <= 1'b1;
        tick(12);
        chk("sample", 32'ha5, {24'h0, smp_out});
        smp   <= 8'h5a;
        stamp <= 1'b0;
        // sample and marker must switch on the same cycle
        for (int k = 0; k < 20 && smp_out !== 8'h5a; k++) begin
            chk("sample", 32'ha5, {24'h0, smp_out});
            tick(1);
        end
        chk("sample", 32'h5a, {24'h0, smp_out});
        wr(12'h160, 8'h00, 1'b0);
        smp <= 8'h3b;
        tick(12);
        chk("sample", 32'h3b, {24'h0, smp_out});
        $display("test marker done");
        apb(1'b0, 12'h3ff, 8'h00);
        chk("pslverr", 32'h1, {31'h0, err});
        chk("prdata", 32'h0, rd);
        wr(12'h302, 8'hff, 1'b1);
        $display("test unmapped done");
        print_verdict();
    end
endmodule : tb_dmlc_regs
